/* File: enc_mt_pkg.sv */
// Shared constants and types for the absolute encoder multi-turn block
package enc_mt_pkg;

  // ==========================================================================
  // Parameter layout
  localparam int unsigned PRM_W = 16;
  localparam int unsigned USAGE_DIGIT_LSB = 8;
  localparam int unsigned USAGE_DIGIT_W = 4;
  localparam logic [3:0] USAGE_ABSOLUTE = 4'h0;
  localparam logic [3:0] USAGE_INCREMENTAL = 4'h1;

  // ==========================================================================
  // Reset values, plus the signed-limit code and the write-protect locked code
  localparam logic [15:0] APP2_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'hffff;
  localparam logic [15:0] LIMIT_SIGNED = 16'hffff;
  localparam logic [15:0] WPROT_RESET = 16'h0000;
  localparam logic [15:0] WPROT_LOCKED = 16'h0001;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ==========================================================================
  // Confirmation steps
  localparam logic [2:0] STEP_FIRST = 3'h1;
  localparam logic [2:0] STEP_LAST = 3'h5;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PRM_APP2,
    PRM_LIMIT,
    PRM_WPROT,
    PRM_NONE
  } prm_sel_t;

  typedef struct packed {
    logic en;
    prm_sel_t sel;
    logic [15:0] data;
  } prm_wr_t;

  typedef enum logic {
    FN_MT_RESET,
    FN_LIMIT_WRITE
  } fn_sel_t;

  typedef struct packed {
    logic start;
    fn_sel_t sel;
    logic step_up;
    logic confirm;
    logic quit;
  } fn_cmd_t;

  typedef struct packed {
    logic backup;
    logic checksum;
    logic other;
    logic mismatch;
  } alarm_t;

endpackage : enc_mt_pkg

/* File: mt_counter.sv */
// Multi-turn revolution counter with programmable wrap
`timescale 1ns/1ps
`default_nettype none

module mt_counter #(
  parameter int unsigned W = 16
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_clear,
  input wire logic i_inc,
  input wire logic i_dec,
  input wire logic [W-1:0] i_limit,
  output logic [W-1:0] o_count
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic signed_mode;

  // All-ones limit runs two's complement, so natural rollover gives the span
  assign signed_mode = (i_limit == enc_mt_pkg::LIMIT_SIGNED);

  always_comb begin
    count_d = count_q;
    if (i_inc && !i_dec) begin
      if (!signed_mode && count_q >= i_limit) begin
        count_d = '0;
      end else begin
        count_d = count_q + 1'b1;
      end
    end else if (i_dec && !i_inc) begin
      if (!signed_mode && count_q == '0) begin
        count_d = i_limit;
      end else if (!signed_mode && count_q > i_limit) begin
        count_d = i_limit;
      end else begin
        count_d = count_q - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_q <= enc_mt_pkg::COUNT_RESET;
    end else if (i_clear) begin
      count_q <= enc_mt_pkg::COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  assign o_count = count_q;

endmodule : mt_counter

`default_nettype wire

/* File: enc_mt_mgmt.sv */
// Absolute encoder usage, multi-turn count, alarms and setup functions
`timescale 1ns/1ps
`default_nettype none

module enc_mt_mgmt (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_power_cycle,
  input wire enc_mt_pkg::prm_wr_t i_prm,
  input wire enc_mt_pkg::fn_cmd_t i_fn,
  input wire logic i_servo_off,
  input wire logic i_net_clear_alarm,
  input wire logic i_backup_err,
  input wire logic i_checksum_err,
  input wire logic i_other_enc_err,
  input wire logic [15:0] i_enc_limit,
  input wire logic i_enc_wr_ack,
  input wire logic i_turn_inc,
  input wire logic i_turn_dec,
  output logic [15:0] o_app2_stored,
  output logic [15:0] o_limit_stored,
  output logic [15:0] o_wprot_stored,
  output logic o_abs_mode,
  output logic [15:0] o_limit_active,
  output logic [15:0] o_mt_count,
  output enc_mt_pkg::alarm_t o_alarm,
  output logic o_setup_required,
  output logic o_enc_wr_req,
  output logic [15:0] o_enc_wr_data,
  output logic o_busy,
  output logic [2:0] o_step,
  output logic o_done,
  output logic o_not_operable
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MT_STEP,
    ST_MT_DONE,
    ST_LW_READY,
    ST_LW_WRITE,
    ST_LW_DONE
  } fn_state_t;

  // ==========================================================================
  // Stored parameters
  logic [15:0] app2_q;
  logic [15:0] limit_q;
  logic [15:0] wprot_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      app2_q <= enc_mt_pkg::APP2_RESET;
      limit_q <= enc_mt_pkg::LIMIT_RESET;
      wprot_q <= enc_mt_pkg::WPROT_RESET;
    end else if (i_prm.en) begin
      unique case (i_prm.sel)
        enc_mt_pkg::PRM_APP2: app2_q <= i_prm.data;
        enc_mt_pkg::PRM_LIMIT: limit_q <= i_prm.data;
        enc_mt_pkg::PRM_WPROT: wprot_q <= i_prm.data;
        enc_mt_pkg::PRM_NONE: ;
      endcase
    end
  end

  // ==========================================================================
  // Settings in force, taken over only on a control power restart
  logic abs_q;
  logic [15:0] limit_act_q;
  logic [3:0] usage_digit;

  assign usage_digit = app2_q[enc_mt_pkg::USAGE_DIGIT_LSB +:
                              enc_mt_pkg::USAGE_DIGIT_W];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      abs_q <= 1'b1;
      limit_act_q <= enc_mt_pkg::LIMIT_RESET;
    end else if (i_power_cycle) begin
      // Digits other than 0 or 1 keep the previous mode
      if (usage_digit == enc_mt_pkg::USAGE_ABSOLUTE) begin
        abs_q <= 1'b1;
      end else if (usage_digit == enc_mt_pkg::USAGE_INCREMENTAL) begin
        abs_q <= 1'b0;
      end
      limit_act_q <= limit_q;
    end
  end

  // ==========================================================================
  // Function sequencer
  fn_state_t state_q;
  logic [2:0] step_q;
  logic refuse_q;
  logic locked;
  logic mt_fire;
  logic lw_done_ev;

  assign locked = (wprot_q == enc_mt_pkg::WPROT_LOCKED);
  assign mt_fire = (state_q == ST_MT_STEP) && i_fn.confirm &&
                   (step_q == enc_mt_pkg::STEP_LAST) && i_servo_off;
  assign lw_done_ev = (state_q == ST_LW_WRITE) && i_enc_wr_ack;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_IDLE;
    end else if (i_fn.quit) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (i_fn.start && !locked) begin
            if (i_fn.sel == enc_mt_pkg::FN_MT_RESET) begin
              if (i_servo_off) begin
                state_q <= ST_MT_STEP;
              end
            end else if (o_alarm.mismatch) begin
              state_q <= ST_LW_READY;
            end
          end
        end
        ST_MT_STEP: begin
          if (mt_fire) begin
            state_q <= ST_MT_DONE;
          end
        end
        ST_MT_DONE: ;
        ST_LW_READY: begin
          if (i_fn.confirm) begin
            state_q <= ST_LW_WRITE;
          end
        end
        ST_LW_WRITE: begin
          if (i_enc_wr_ack) begin
            state_q <= ST_LW_DONE;
          end
        end
        ST_LW_DONE: ;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Confirmation counter saturates at the last step
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      step_q <= '0;
    end else if (state_q == ST_IDLE) begin
      step_q <= enc_mt_pkg::STEP_FIRST;
    end else if (state_q == ST_MT_STEP && i_fn.step_up &&
                 step_q < enc_mt_pkg::STEP_LAST) begin
      step_q <= step_q + 3'h1;
    end
  end

  // Refusal indication holds until the operator quits or starts a function while unlocked
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      refuse_q <= 1'b0;
    end else if (state_q == ST_IDLE && i_fn.start && locked) begin
      refuse_q <= 1'b1;
    end else if (i_fn.quit || (i_fn.start && !locked)) begin
      refuse_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Encoder limit write: copies the stored parameter with no range check
  logic [15:0] wr_data_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_data_q <= '0;
    end else if (state_q == ST_LW_READY && i_fn.confirm) begin
      wr_data_q <= limit_q;
    end
  end

  // ==========================================================================
  // Alarms; a set in the same cycle as its clear wins
  enc_mt_pkg::alarm_t alm_q;
  logic mismatch_seen;

  // The limit being taken into force is the one the encoder must match
  assign mismatch_seen = (i_enc_limit != limit_q);

  // Network clear is ignored: none of these alarms answer to it
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      alm_q <= '0;
    end else begin
      alm_q.backup <= i_backup_err || (alm_q.backup && !mt_fire);
      alm_q.checksum <= i_checksum_err ||
                        (alm_q.checksum && !mt_fire);
      alm_q.other <= i_other_enc_err ||
                     (alm_q.other && !i_power_cycle);
      // Compared only at startup; a later encoder reload does not re-alarm
      if (i_power_cycle) begin
        alm_q.mismatch <= mismatch_seen;
      end else if (lw_done_ev) begin
        alm_q.mismatch <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Multi-turn counter
  logic cnt_clear;

  assign cnt_clear = mt_fire || (i_power_cycle && usage_digit !=
                                 enc_mt_pkg::USAGE_ABSOLUTE);

  mt_counter #(
    .W(enc_mt_pkg::PRM_W)
  ) u_count (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_clear(cnt_clear),
    .i_inc(i_turn_inc && abs_q),
    .i_dec(i_turn_dec && abs_q),
    .i_limit(limit_act_q),
    .o_count(o_mt_count)
  );

  // ==========================================================================
  // Outputs
  assign o_app2_stored = app2_q;
  assign o_limit_stored = limit_q;
  assign o_wprot_stored = wprot_q;
  assign o_abs_mode = abs_q;
  assign o_limit_active = limit_act_q;
  assign o_alarm = alm_q;
  assign o_setup_required = alm_q.backup || alm_q.checksum;
  assign o_enc_wr_req = (state_q == ST_LW_WRITE);
  assign o_enc_wr_data = wr_data_q;
  assign o_busy = (state_q != ST_IDLE);
  assign o_step = step_q;
  assign o_done = (state_q == ST_MT_DONE) || (state_q == ST_LW_DONE);
  assign o_not_operable = refuse_q;

  // ==========================================================================
  // Checks
  abs_mode_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_power_cycle |=> $stable(abs_q))
    else $error("Encoder mode changed without power cycle");

  usage_select_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_power_cycle && usage_digit == enc_mt_pkg::USAGE_INCREMENTAL
    |=> !abs_q)
    else $error("Incremental digit did not select incremental use");

  limit_apply_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_power_cycle |=> limit_act_q == $past(limit_q))
    else $error("Active limit not taken at power cycle");

  servo_on_block_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    state_q == ST_IDLE && i_fn.start && !i_fn.quit &&
    i_fn.sel == enc_mt_pkg::FN_MT_RESET && !i_servo_off
    |=> state_q == ST_IDLE)
    else $error("Setup entered while servo on");

  backup_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    alm_q.backup && !mt_fire && i_net_clear_alarm |=> alm_q.backup)
    else $error("Backup alarm cleared by network clear");

  other_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    alm_q.other && !i_power_cycle |=> alm_q.other)
    else $error("Other encoder alarm cleared without power cycle");

  reset_step_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    mt_fire && !i_fn.quit |=> o_done && o_mt_count == '0 &&
    (!o_setup_required || $past(i_backup_err || i_checksum_err)))
    else $error("Multi-turn reset did not complete");

  early_confirm_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    state_q == ST_MT_STEP && step_q < enc_mt_pkg::STEP_LAST && !i_fn.quit
    |=> state_q != ST_MT_DONE)
    else $error("Reset ran before the last confirm step");

  protect_refuse_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    state_q == ST_IDLE && i_fn.start && locked && !i_fn.quit
    |=> o_not_operable && !o_busy)
    else $error("Write protect did not refuse the function");

  limit_gate_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    state_q == ST_IDLE && i_fn.start && !alm_q.mismatch &&
    i_fn.sel == enc_mt_pkg::FN_LIMIT_WRITE |=> state_q != ST_LW_READY)
    else $error("Limit write entered without mismatch alarm");

  mismatch_raise_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_power_cycle && mismatch_seen |=> alm_q.mismatch)
    else $error("Mismatch not raised at startup");

  limit_copy_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    state_q == ST_LW_READY && i_fn.confirm && !i_fn.quit
    |=> o_enc_wr_req && o_enc_wr_data == $past(limit_q))
    else $error("Encoder write data differs from stored limit");

  limit_done_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    lw_done_ev && !i_fn.quit && !i_power_cycle
    |=> o_done && !alm_q.mismatch ##0 $stable(limit_act_q))
    else $error("Limit write did not finish cleanly");

endmodule : enc_mt_mgmt

`default_nettype wire

/* File: enc_model.sv */
// Encoder partner model: stored multi-turn limit and write acknowledge
`timescale 1ns/1ps
`default_nettype none

module enc_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_slow,
  input wire logic i_wr_req,
  input wire logic [15:0] i_wr_data,
  output logic [15:0] o_limit,
  output logic o_ack
);
  logic busy_q;
  logic acked_q;
  logic [3:0] wait_q;

  // ======================================================
  // Write handshake, prompt or slow
  // Acknowledges once per request and waits for the request to drop,
  // so a held request is never taken twice
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_limit <= 16'hffff;
      o_ack <= 1'b0;
      busy_q <= 1'b0;
      acked_q <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      o_ack <= 1'b0;
      if (!busy_q) begin
        if (i_wr_req) begin
          busy_q <= 1'b1;
          wait_q <= i_slow ? 4'h4 : 4'h0;
        end
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (!acked_q) begin
        o_ack <= 1'b1;
        acked_q <= 1'b1;
        o_limit <= i_wr_data;
      end else if (!i_wr_req) begin
        busy_q <= 1'b0;
        acked_q <= 1'b0;
      end
    end
  end
endmodule : enc_model

`default_nettype wire

/* File: tb_absolute_encoder_multiturn_mgmt.sv */
// Self-checking testbench for the encoder multi-turn block
`timescale 1ns/1ps
`default_nettype none

module tb_absolute_encoder_multiturn_mgmt;
  typedef struct packed {
    logic [3:0] s;
    logic [15:0] v;
  } note_t;
  localparam logic [3:0] S_APP = 4'h0, S_LST = 4'h1, S_WP = 4'h2;
  localparam logic [3:0] S_LACT = 4'h3, S_CNT = 4'h4, S_ALM = 4'h5;
  localparam logic [3:0] S_STEP = 4'h6, S_WD = 4'h7, S_ABS = 4'h8;
  localparam logic [3:0] S_SREQ = 4'h9, S_BUSY = 4'ha, S_DONE = 4'hb;
  localparam logic [3:0] S_NOP = 4'hc, S_REQ = 4'hd;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_power_cycle = 1'b0;
  enc_mt_pkg::prm_wr_t i_prm = '0;
  enc_mt_pkg::fn_cmd_t i_fn = '0;
  logic i_servo_off = 1'b1;
  logic i_net_clear_alarm = 1'b0;
  logic i_backup_err = 1'b0;
  logic i_checksum_err = 1'b0;
  logic i_other_enc_err = 1'b0;
  logic i_turn_inc = 1'b0;
  logic i_turn_dec = 1'b0;
  logic enc_slow = 1'b1;
  logic enc_ack;
  logic [15:0] enc_limit, app2, lst, wp, lact, cnt, wd;
  logic abs_m, sreq, req, busy, done, nop;
  logic [2:0] step;
  enc_mt_pkg::alarm_t alm;
  note_t q[$];
  int n_mismatch = 0;
  int check_count = 0;
  event look_ev;

  enc_mt_mgmt u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_power_cycle(i_power_cycle), .i_prm(i_prm), .i_fn(i_fn),
    .i_servo_off(i_servo_off), .i_net_clear_alarm(i_net_clear_alarm),
    .i_backup_err(i_backup_err), .i_checksum_err(i_checksum_err),
    .i_other_enc_err(i_other_enc_err), .i_enc_limit(enc_limit),
    .i_enc_wr_ack(enc_ack), .i_turn_inc(i_turn_inc),
    .i_turn_dec(i_turn_dec), .o_app2_stored(app2), .o_limit_stored(lst),
    .o_wprot_stored(wp), .o_abs_mode(abs_m), .o_limit_active(lact),
    .o_mt_count(cnt), .o_alarm(alm), .o_setup_required(sreq),
    .o_enc_wr_req(req), .o_enc_wr_data(wd), .o_busy(busy),
    .o_step(step), .o_done(done), .o_not_operable(nop));

  enc_model u_enc (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_slow(enc_slow),
    .i_wr_req(req), .i_wr_data(wd), .o_limit(enc_limit), .o_ack(enc_ack));

  initial begin
    forever #25 i_clk = ~i_clk;
  end

  // ======================================================
  // Checking
  function automatic logic [15:0] pick(input logic [3:0] s);
    case (s)
      S_APP: pick = app2;
      S_LST: pick = lst;
      S_WP: pick = wp;
      S_LACT: pick = lact;
      S_CNT: pick = cnt;
      S_ALM: pick = {12'h000, alm};
      S_STEP: pick = {13'h0000, step};
      S_WD: pick = wd;
      S_ABS: pick = {15'h0000, abs_m};
      S_SREQ: pick = {15'h0000, sreq};
      S_BUSY: pick = {15'h0000, busy};
      S_DONE: pick = {15'h0000, done};
      S_NOP: pick = {15'h0000, nop};
      default: pick = {15'h0000, req};
    endcase
  endfunction : pick

  task automatic cmp_word(input logic [3:0] s, input logic [15:0] e,
                          input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t sel=%h exp=%h got=%h", $time, s, e, g);
    end
  endtask : cmp_word

  task automatic cmp_flag(input logic [3:0] s, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t sel=%h exp=%h got=%h", $time, s, e, g);
    end
  endtask : cmp_flag

  // Watcher takes every queued note, oldest first, each time a result is announced
  initial begin
    note_t n;
    logic [15:0] g;
    forever begin
      @(look_ev);
      while (q.size() > 0) begin
        n = q.pop_front();
        g = pick(n.s);
        if (n.s[3]) cmp_flag(n.s, n.v[0], g[0]);
        else cmp_word(n.s, n.v, g);
      end
    end
  end

  task automatic report_and_stop;
    // Lets the watcher take the last notes first
    #1;
    $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // ======================================================
  // Drivers
  task automatic cyc;
    @(posedge i_clk);
    #2;
  endtask : cyc

  task automatic ck(input logic [3:0] s, input logic [15:0] v);
    q.push_back('{s, v});
    -> look_ev;
  endtask : ck

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc();
    s = 1'b0;
  endtask : pulse

  task automatic prm(input enc_mt_pkg::prm_sel_t s, input logic [15:0] d);
    i_prm = '{en: 1'b1, sel: s, data: d};
    cyc();
    i_prm = '0;
  endtask : prm

  task automatic key(input logic [4:0] k);
    i_fn = enc_mt_pkg::fn_cmd_t'(k);
    cyc();
    i_fn = '0;
  endtask : key

  task automatic turns(input logic up, input logic dn, input int n);
    i_turn_inc = up;
    i_turn_dec = dn;
    repeat (n) cyc();
    i_turn_inc = 1'b0;
    i_turn_dec = 1'b0;
  endtask : turns

  // ======================================================
  // Main sequence
  initial begin
    logic [7:0] r;
    int n;
    void'($urandom(32'h4af2_9119));
    repeat (4) @(posedge i_clk);
    #2;
    i_arst_n = 1'b1;
    ck(S_LST, 16'hffff);
    ck(S_LACT, 16'hffff);
    pulse(i_power_cycle);
    ck(S_ALM, 16'h0000);
    turns(1'b0, 1'b1, 1);
    ck(S_CNT, 16'hffff);
    turns(1'b1, 1'b1, 1);
    turns(1'b1, 1'b0, 1);
    ck(S_CNT, 16'h0000);
    turns(1'b1, 1'b0, 32767);
    ck(S_CNT, 16'h7fff);
    turns(1'b1, 1'b0, 1);
    ck(S_CNT, 16'h8000);
    pulse(i_backup_err);
    ck(S_SREQ, 16'h0001);
    pulse(i_net_clear_alarm);
    ck(S_ALM, 16'h0008);
    pulse(i_checksum_err);
    pulse(i_other_enc_err);
    pulse(i_net_clear_alarm);
    ck(S_ALM, 16'h000e);
    i_servo_off = 1'b0;
    key(5'h10);
    ck(S_BUSY, 16'h0000);
    i_servo_off = 1'b1;
    prm(enc_mt_pkg::PRM_WPROT, 16'h0001);
    ck(S_WP, 16'h0001);
    key(5'h10);
    ck(S_NOP, 16'h0001);
    ck(S_BUSY, 16'h0000);
    key(5'h01);
    key(5'h18);
    ck(S_NOP, 16'h0001);
    key(5'h01);
    prm(enc_mt_pkg::PRM_WPROT, 16'h0000);
    key(5'h10);
    ck(S_STEP, 16'h0001);
    repeat (3) key(5'h04);
    key(5'h02);
    ck(S_DONE, 16'h0000);
    repeat (3) key(5'h04);
    ck(S_STEP, 16'h0005);
    key(5'h02);
    ck(S_DONE, 16'h0001);
    ck(S_CNT, 16'h0000);
    ck(S_ALM, 16'h0002);
    key(5'h01);
    pulse(i_power_cycle);
    ck(S_ALM, 16'h0000);
    r = 8'($urandom());
    prm(enc_mt_pkg::PRM_APP2, {8'h01, r});
    ck(S_APP, {8'h01, r});
    turns(1'b1, 1'b0, 1);
    ck(S_ABS, 16'h0001);
    ck(S_CNT, 16'h0001);
    pulse(i_power_cycle);
    ck(S_ABS, 16'h0000);
    turns(1'b1, 1'b0, 1);
    ck(S_CNT, 16'h0000);
    prm(enc_mt_pkg::PRM_APP2, 16'h0000);
    pulse(i_power_cycle);
    ck(S_ABS, 16'h0001);
    key(5'h18);
    ck(S_BUSY, 16'h0000);
    prm(enc_mt_pkg::PRM_LIMIT, 16'h0009);
    ck(S_LACT, 16'hffff);
    pulse(i_power_cycle);
    ck(S_LACT, 16'h0009);
    ck(S_ALM, 16'h0001);
    pulse(i_power_cycle);
    ck(S_ALM, 16'h0001);
    turns(1'b0, 1'b1, 1);
    ck(S_CNT, 16'h0009);
    turns(1'b1, 1'b0, 1);
    ck(S_CNT, 16'h0000);
    n = $urandom_range(15, 1);
    turns(1'b1, 1'b0, n);
    ck(S_CNT, 16'(n % 10));
    key(5'h18);
    key(5'h02);
    ck(S_REQ, 16'h0001);
    ck(S_WD, 16'h0009);
    for (int i = 0; i < 30 && done !== 1'b1; i++) cyc();
    if (done !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
    ck(S_DONE, 16'h0001);
    ck(S_ALM, 16'h0000);
    key(5'h01);
    pulse(i_power_cycle);
    ck(S_ALM, 16'h0000);
    ck(S_LACT, 16'h0009);
    // Second limit write, with the encoder answering at once
    r = 8'($urandom());
    prm(enc_mt_pkg::PRM_LIMIT, {8'h01, r});
    pulse(i_power_cycle);
    ck(S_ALM, 16'h0001);
    enc_slow = 1'b0;
    key(5'h18);
    key(5'h02);
    ck(S_WD, {8'h01, r});
    for (int i = 0; i < 30 && done !== 1'b1; i++) cyc();
    if (done !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
    ck(S_DONE, 16'h0001);
    ck(S_ALM, 16'h0000);
    key(5'h01);
    report_and_stop();
  end
endmodule : tb_absolute_encoder_multiturn_mgmt

`default_nettype wire
